// file: verilog/oad_consts.svh
/*
 * Constants for the operand addressing and data map block: data-space
 * offsets, region bounds, field positions and reset values.
 * Assumes inclusion by bare name; definitions only.
 */
// Behaviour
// RULE_01: Indirect operand addressed by first/second pointer
// RULE_02: Direct mode uses 8-bit instruction address
// RULE_03: Immediate mode uses instruction byte, no access
// RULE_04: Auto inc/dec pointer after instruction executes
// RULE_05: Short jump adds signed offset -31..+32; code jumps -31..+31 only, and offset -32 steps the PC
// RULE_06: Offset of one executes as no-operation
// RULE_07: Jump target spans full 15-bit counter
// RULE_08: RAM, ports, registers share one data space
// RULE_09: Small RAM: 00-2F RAM, 30-7F unused
// RULE_10: Large RAM: 00-6F RAM, 70-7F unused
// RULE_11: Unused locations below 7F read all ones
// RULE_12: 80-CF reserved, nothing implemented there
// RULE_13: Port registers D0-DF; pin inputs read-only
// RULE_14: Shift, timer, reload registers at E9-ED
// RULE_15: F0-FF register RAM; pointers at FC/FD/FE
// RULE_16: Register operands restricted to F0-FF
// RULE_17: Bit instructions select bit 0 to 7
// RULE_18: Carry ops update accumulator, carry, half-carry
// RULE_19: Equality test skips next when unequal
// RULE_20: Pointer inc/dec wraps modulo 256
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH

// ****************************************
// Data-space region bounds
// ****************************************
`define OAD_SMALL_RAM_TOP  8'h2F
`define OAD_LARGE_RAM_TOP  8'h6F
`define OAD_UNUSED_TOP     8'h7F
`define OAD_REG_RAM_BASE   8'hF0
`define OAD_LARGE_RAM_SIZE 112

// ****************************************
// Register offsets
// ****************************************
`define OAD_P1_LATCH   8'hD0
`define OAD_P1_DIR     8'hD1
`define OAD_P1_PINS    8'hD2
`define OAD_P2_LATCH   8'hD4
`define OAD_P2_DIR     8'hD5
`define OAD_P2_PINS    8'hD6
`define OAD_PI_PINS    8'hD7
`define OAD_P3_LATCH   8'hD8
`define OAD_P3_DIR     8'hD9
`define OAD_P3_PINS    8'hDA
`define OAD_PD_LATCH   8'hDC
`define OAD_SHIFT      8'hE9
`define OAD_TMR_LO     8'hEA
`define OAD_TMR_HI     8'hEB
`define OAD_RLD_LO     8'hEC
`define OAD_RLD_HI     8'hED
`define OAD_CTRL       8'hEE
`define OAD_PSW        8'hEF
`define OAD_SECOND_PTR 8'hFC
`define OAD_STACK_PTR  8'hFD
`define OAD_FIRST_PTR  8'hFE

// ****************************************
// Field positions and values
// ****************************************
`define OAD_PSW_CARRY_BIT  6
`define OAD_PSW_HALF_BIT   7
`define OAD_ALL_ONES       8'hFF
`define OAD_ZERO_BYTE      8'h00
`define OAD_JUMP_MIN       -31
`define OAD_JUMP_MAX       32
`define OAD_PC_RESET       15'h0000

`endif

// file: verilog/oad_pkg.sv
/*
 * Types for the operand addressing and data map block.
 * Assumes the constants header is compiled alongside.
 */
package oad_pkg;

  // ****************************************
  // Operand modes
  // ****************************************
  typedef enum logic [4:0] {
    OAD_MODE_INDIRECT = 5'h01,
    OAD_MODE_DIRECT   = 5'h02,
    OAD_MODE_IMMED    = 5'h04,
    OAD_MODE_AUTO     = 5'h08,
    OAD_MODE_REG      = 5'h10
  } oad_mode_t;

  // Operations executed on the resolved operand
  typedef enum logic [3:0] {
    OAD_OP_NONE  = 4'h0,
    OAD_OP_LOAD  = 4'h1,
    OAD_OP_STORE = 4'h2,
    OAD_OP_ADC   = 4'h3,
    OAD_OP_SUBTRACT_WITH_CARRY_OP  = 4'h4,
    OAD_OP_EQ    = 4'h5,
    OAD_OP_SBIT  = 4'h6,
    OAD_OP_RBIT  = 4'h7,
    OAD_OP_JUMP  = 4'h8
  } oad_op_t;

  // One decoded instruction presented by the core
  typedef struct packed {
    logic      valid;       // Instruction present this cycle
    oad_op_t   op;          // Operation
    oad_mode_t mode;        // Operand mode
    logic      use_second;  // Select second pointer instead of first
    logic      decrement;   // Auto mode: decrement, else increment
    logic [7:0] field;      // Address, immediate or register offset
    logic [2:0] bit_sel;    // Bit number for bit operations
    logic signed [5:0] rel; // Short relative jump offset
  } oad_instr_t;

  // Result of one instruction
  typedef struct packed {
    logic       done;       // Instruction finished
    logic       skip;       // Next instruction to be skipped
    logic       no_operation;        // Jump slot executed as no-operation
    logic [7:0] acc;        // Accumulator
    logic       carry;      // Carry flag
    logic       half;       // Half-carry flag
    logic [14:0] pc;        // Program counter
  } oad_result_t;

  // Block state other than RAM, register RAM and pin synchronisers
  typedef struct packed {
    logic [7:0]  acc;
    logic [14:0] pc;
    logic        carry;
    logic        half;
    logic        skip;
    logic        no_operation;
    logic        done;
    logic [7:0]  p1_latch;
    logic [7:0]  p1_dir;
    logic [7:0]  p2_latch;
    logic [7:0]  p2_dir;
    logic [7:0]  p3_latch;
    logic [7:0]  p3_dir;
    logic [7:0]  pd_latch;
    logic [7:0]  shift;
    logic [7:0]  tmr_lo;
    logic [7:0]  tmr_hi;
    logic [7:0]  rld_lo;
    logic [7:0]  rld_hi;
    logic [7:0]  ctrl;
    logic [5:0]  psw_rest;  // Status bits 5..0
  } oad_state_t;

endpackage

// file: verilog/oad_data_map.sv
/*
 * Operand resolution, data-space decode and operand arithmetic for the
 * core. One instruction is taken per cycle and finished in that cycle.
 * Assumes the core presents decoded instructions on the same clock and
 * that port pin levels arrive asynchronously from the package.
 */
`timescale 1ns/100ps
`include "oad_consts.svh"

module oad_data_map
  import oad_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Configuration
  input  wire logic        i_large_ram,   // Large RAM option selected
  // Instruction side
  input  wire oad_instr_t  i_instr,
  // Port pins (asynchronous)
  input  wire logic [7:0]  i_p1_pins,
  input  wire logic [7:0]  i_p2_pins,
  input  wire logic [7:0]  i_pi_pins,
  input  wire logic [7:0]  i_p3_pins,
  // Results
  output oad_result_t      o_result,
  output logic [7:0]       o_first_ptr,
  output logic [7:0]       o_second_ptr,
  output logic [7:0]       o_stack_ptr,
  output logic [7:0]       o_p1_latch,
  output logic [7:0]       o_p1_dir,
  output logic [7:0]       o_p2_latch,
  output logic [7:0]       o_p2_dir,
  output logic [7:0]       o_p3_latch,
  output logic [7:0]       o_p3_dir,
  output logic [7:0]       o_pd_latch
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  ram_q [`OAD_LARGE_RAM_SIZE];  // Main data RAM
  logic [7:0]  reg_q [16];                   // Register RAM F0-FF
  oad_state_t  st_q;                         // Block state
  oad_state_t  st_d;                         // Next block state

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [31:0] pin_raw;                      // All pin inputs
  logic [31:0] pin_s1_q;                     // First stage
  logic [31:0] pin_s2_q;                     // Second stage
  logic [31:0] pin_s3_q;                     // Third stage
  logic [31:0] pin_q;                        // Accepted level

  assign pin_raw = {i_p3_pins, i_pi_pins, i_p2_pins, i_p1_pins};

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    // Shift chain, no reset
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    // Level clears on reset
    if (i_rst) begin
      pin_q <= 32'h00000000;
    end else begin
      // Per bit, once settled
      for (int b = 0; b < 32; b++) begin
        if (pin_s2_q[b] == pin_s3_q[b]) begin
          pin_q[b] <= pin_s3_q[b];
        end
      end
    end
  end

  // ****************************************
  // Address resolution
  // ****************************************
  logic [7:0] ptr_sel;     // Selected pointer value
  logic [7:0] addr;        // Effective data address
  logic       mem_access;  // Operand comes from data memory
  logic [7:0] rd_data;     // Data read at addr
  logic [7:0] operand;     // Operand value
  logic [3:0] reg_idx;     // Index into register RAM

  // Pointer select and effective address
  always_comb begin
    ptr_sel = i_instr.use_second ? reg_q[4'hC] : reg_q[4'hE]; // RULE_01
    addr       = ptr_sel;
    mem_access = 1'b1;
    // Mode picks the source
    unique case (i_instr.mode)
      OAD_MODE_INDIRECT: addr = ptr_sel;                    // RULE_01
      OAD_MODE_AUTO:     addr = ptr_sel;                    // RULE_04
      OAD_MODE_DIRECT:   addr = i_instr.field;              // RULE_02
      OAD_MODE_REG:      addr = {4'hF, i_instr.field[3:0]}; // RULE_16
      OAD_MODE_IMMED:    mem_access = 1'b0;                 // RULE_03
      default:           addr = ptr_sel;  // Idle slot
    endcase
  end

  // Register RAM index
  assign reg_idx = addr[3:0];

  // Data-space read decode
  always_comb begin
    rd_data = `OAD_ALL_ONES;
    if (addr <= `OAD_UNUSED_TOP) begin
      // Unused low locations read all ones
      if (addr <= (i_large_ram ? `OAD_LARGE_RAM_TOP
                               : `OAD_SMALL_RAM_TOP)) begin // RULE_09
        // RAM present here
        rd_data = ram_q[addr[6:0]];                         // RULE_10
      end else begin
        rd_data = `OAD_ALL_ONES;                            // RULE_11
      end
    end else if (addr >= `OAD_REG_RAM_BASE) begin
      // Register RAM F0-FF
      rd_data = reg_q[reg_idx];                             // RULE_15
    end else begin
      // 80-CF expansion and reserved holes: nothing here    RULE_12
      unique case (addr)
        `OAD_P1_LATCH: rd_data = st_q.p1_latch;             // RULE_13
        `OAD_P1_DIR:   rd_data = st_q.p1_dir;
        `OAD_P1_PINS:  rd_data = pin_q[7:0];
        `OAD_P2_LATCH: rd_data = st_q.p2_latch;
        `OAD_P2_DIR:   rd_data = st_q.p2_dir;
        `OAD_P2_PINS:  rd_data = pin_q[15:8];
        `OAD_PI_PINS:  rd_data = pin_q[23:16];
        `OAD_P3_LATCH: rd_data = st_q.p3_latch;
        `OAD_P3_DIR:   rd_data = st_q.p3_dir;
        `OAD_P3_PINS:  rd_data = pin_q[31:24];
        `OAD_PD_LATCH: rd_data = st_q.pd_latch;
        `OAD_SHIFT:    rd_data = st_q.shift;                // RULE_14
        `OAD_TMR_LO:   rd_data = st_q.tmr_lo;
        `OAD_TMR_HI:   rd_data = st_q.tmr_hi;
        `OAD_RLD_LO:   rd_data = st_q.rld_lo;
        `OAD_RLD_HI:   rd_data = st_q.rld_hi;
        `OAD_CTRL:     rd_data = st_q.ctrl;
        `OAD_PSW:      rd_data = {st_q.half, st_q.carry, st_q.psw_rest};
        default:       rd_data = `OAD_ALL_ONES;             // RULE_08
      endcase
    end
  end

  assign operand = mem_access ? rd_data : i_instr.field;    // RULE_03

  // ****************************************
  // Execution
  // ****************************************
  logic       run;          // Instruction executes (not skipped)
  logic       wr_en;        // Data memory write this cycle
  logic [7:0] wr_data;      // Data written at addr
  logic [8:0] sum;          // Carry arithmetic result
  logic [4:0] half_sum;     // Low nibble result
  logic [7:0] add_val;      // Operand or its complement
  logic [14:0] pc_rel;      // Relative jump target
  logic       ptr_step;     // Pointer update due

  // Skip eats one slot
  assign run = i_instr.valid && !st_q.skip;

  // Next-state logic for accumulator, flags, PC and stores
  always_comb begin
    st_d     = st_q;
    wr_en    = 1'b0;
    wr_data  = st_q.acc;
    add_val  = (i_instr.op == OAD_OP_SUBTRACT_WITH_CARRY_OP) ? ~operand : operand;
    sum      = 9'({1'b0, st_q.acc} + {1'b0, add_val}
                  + {8'h00, st_q.carry});                   // RULE_18
    half_sum = 5'({1'b0, st_q.acc[3:0]} + {1'b0, add_val[3:0]}
                  + {4'h0, st_q.carry});
    // Target over all 15 bits
    pc_rel   = 15'(st_q.pc + {{9{i_instr.rel[5]}}, i_instr.rel});
    st_d.done = i_instr.valid;
    st_d.no_operation  = 1'b0;
    // Each valid slot steps the PC
    if (i_instr.valid) begin
      st_d.skip = 1'b0;
      st_d.pc   = 15'(st_q.pc + 15'h0001);
    end
    // Skipped slot does no more
    if (run) begin
      unique case (i_instr.op)
        OAD_OP_LOAD: st_d.acc = operand;
        OAD_OP_STORE: begin
          // Accumulator out
          wr_en = mem_access;
        end
        OAD_OP_ADC, OAD_OP_SUBTRACT_WITH_CARRY_OP: begin
          // Flags from the sum
          st_d.acc   = sum[7:0];                            // RULE_18
          st_d.carry = sum[8];
          st_d.half  = half_sum[4];
        end
        OAD_OP_EQ: st_d.skip = (st_q.acc != operand);       // RULE_19
        OAD_OP_SBIT, OAD_OP_RBIT: begin
          // Read, modify, write
          wr_en   = mem_access;
          wr_data = rd_data;
          wr_data[i_instr.bit_sel] =
            (i_instr.op == OAD_OP_SBIT);                    // RULE_17
        end
        OAD_OP_JUMP: begin
          // Offset -32: plain step
          if (i_instr.rel == 6'sd1) begin
            st_d.no_operation = 1'b1;                                // RULE_06
          end else if (i_instr.rel >= 6'sd0 - 6'sd31) begin
            st_d.pc = pc_rel;                               // RULE_05 RULE_07
          end
        end
        default: ;
      endcase
    end
    // Writes to the mapped registers; pin inputs ignore writes
    if (wr_en) begin
      unique case (addr)
        `OAD_P1_LATCH: st_d.p1_latch = wr_data;             // RULE_13
        `OAD_P1_DIR:   st_d.p1_dir   = wr_data;
        `OAD_P2_LATCH: st_d.p2_latch = wr_data;
        `OAD_P2_DIR:   st_d.p2_dir   = wr_data;
        `OAD_P3_LATCH: st_d.p3_latch = wr_data;
        `OAD_P3_DIR:   st_d.p3_dir   = wr_data;
        `OAD_PD_LATCH: st_d.pd_latch = wr_data;
        `OAD_SHIFT:    st_d.shift    = wr_data;             // RULE_14
        `OAD_TMR_LO:   st_d.tmr_lo   = wr_data;
        `OAD_TMR_HI:   st_d.tmr_hi   = wr_data;
        `OAD_RLD_LO:   st_d.rld_lo   = wr_data;
        `OAD_RLD_HI:   st_d.rld_hi   = wr_data;
        `OAD_CTRL:     st_d.ctrl     = wr_data;
        `OAD_PSW: begin
          // Flags in top bits
          st_d.half     = wr_data[`OAD_PSW_HALF_BIT];
          st_d.carry    = wr_data[`OAD_PSW_CARRY_BIT];
          st_d.psw_rest = wr_data[5:0];
        end
        default: ;
      endcase
    end
  end

  // Auto mode steps pointer
  assign ptr_step = run && (i_instr.mode == OAD_MODE_AUTO);

  // Block state register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      // PC to reset vector
      st_q    <= '0;
      st_q.pc <= `OAD_PC_RESET;
    end else begin
      // Next state
      st_q <= st_d;
    end
  end

  // ****************************************
  // RAM and register RAM
  // ****************************************
  logic ram_hit;  // Write lands in main RAM
  assign ram_hit = addr <= (i_large_ram ? `OAD_LARGE_RAM_TOP
                                         : `OAD_SMALL_RAM_TOP);

  // One write path per entry
  genvar g;
  generate
    for (g = 0; g < `OAD_LARGE_RAM_SIZE; g++) begin : g_ram
      // Not cleared by reset
      always_ff @(posedge i_clk_sys) begin
        if (wr_en && ram_hit && addr[6:0] == 7'(g)) begin
          ram_q[g] <= wr_data;
        end
      end
    end
    // Register RAM and pointers
    for (g = 0; g < 16; g++) begin : g_reg
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          // Pointers start at zero
          reg_q[g] <= `OAD_ZERO_BYTE;
        end else if (wr_en && addr >= `OAD_REG_RAM_BASE
                     && reg_idx == 4'(g)) begin
          // Write beats a step
          reg_q[g] <= wr_data;                              // RULE_15
        end else if (ptr_step && ((g == 12 && i_instr.use_second)
                     || (g == 14 && !i_instr.use_second))) begin
          // Step after use; 8-bit arithmetic wraps at 256
          reg_q[g] <= i_instr.decrement
                      ? 8'(reg_q[g] - 8'h01)                // RULE_04
                      : 8'(reg_q[g] + 8'h01);               // RULE_20
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  // Result bundle
  assign o_result.done  = st_q.done;
  assign o_result.skip  = st_q.skip;
  assign o_result.no_operation   = st_q.no_operation;
  assign o_result.acc   = st_q.acc;
  assign o_result.carry = st_q.carry;
  assign o_result.half  = st_q.half;
  assign o_result.pc    = st_q.pc;
  // Pointer registers
  assign o_first_ptr    = reg_q[4'hE];
  assign o_second_ptr   = reg_q[4'hC];
  assign o_stack_ptr    = reg_q[4'hD];
  // Port registers
  assign o_p1_latch     = st_q.p1_latch;
  assign o_p1_dir       = st_q.p1_dir;
  assign o_p2_latch     = st_q.p2_latch;
  assign o_p2_dir       = st_q.p2_dir;
  assign o_p3_latch     = st_q.p3_latch;
  assign o_p3_dir       = st_q.p3_dir;
  assign o_pd_latch     = st_q.pd_latch;

  // ****************************************
  // Assertions
  // ****************************************
  // Pointer stepping
  AST_PTR_INC: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_04
    ptr_step && !i_instr.decrement && !i_instr.use_second
    |=> o_first_ptr == 8'($past(o_first_ptr) + 8'h01))
    else $error("first pointer did not step up");
  AST_PTR_WRAP: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_20
    ptr_step && i_instr.decrement && !i_instr.use_second
    && o_first_ptr == 8'h00 |=> o_first_ptr == 8'hFF)
    else $error("first pointer did not wrap");
  // Data-space decode
  AST_UNUSED: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_11
    addr > 8'h6F && addr <= 8'h7F |-> rd_data == 8'hFF)
    else $error("unused location not all ones");
  // Jump slot
  AST_NOP: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_06
    run && i_instr.op == OAD_OP_JUMP && i_instr.rel == 6'sd1
    |=> o_result.no_operation && o_result.pc == 15'($past(o_result.pc) + 15'h1))
    else $error("jump of one not a no-operation");
  AST_JUMP: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_07
    run && i_instr.op == OAD_OP_JUMP && i_instr.rel != 6'h01
    && i_instr.rel != 6'h20 |=> o_result.pc == 15'($past(o_result.pc)
    + {{9{$past(i_instr.rel[5])}}, $past(i_instr.rel)}))
    else $error("jump target wrong");
  // Operand resolution
  AST_EQ: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_19
    run && i_instr.op == OAD_OP_EQ |=> o_result.skip
    == ($past(st_q.acc) != $past(operand)))
    else $error("equality skip wrong");
  AST_IMM: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_03
    i_instr.mode == OAD_MODE_IMMED |-> !wr_en && operand == i_instr.field)
    else $error("immediate touched memory");
  AST_PINS_RO: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_13
    wr_en && addr == 8'hD2 |=> $stable(o_p1_latch) && $stable(o_p1_dir))
    else $error("pin input write had effect");
  AST_REG: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE_16
    i_instr.mode == OAD_MODE_REG |-> addr[7:4] == 4'hF)
    else $error("register operand outside F0-FF");
  // Main scenarios
  COV_JUMP: cover property (@(posedge i_clk_sys)
    run && i_instr.op == OAD_OP_JUMP);
  COV_AUTO: cover property (@(posedge i_clk_sys) ptr_step);
  COV_SKIP: cover property (@(posedge i_clk_sys) o_result.skip);
  COV_NOP: cover property (@(posedge i_clk_sys) o_result.no_operation);
  COV_WRAP: cover property (@(posedge i_clk_sys)
    ptr_step && i_instr.decrement && o_first_ptr == 8'h00);

endmodule

// file: tb/tb_oad_data_map.sv
/*
 * Self-checking bench for the operand addressing and data map block.
 * Assumes oad_pkg and the design are compiled first, and that the block
 * takes one pre-decoded instruction per valid cycle.
 */
`timescale 1ns/100ps

module tb_oad_data_map
  import oad_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        i_clk_sys;   // 100 MHz clock
  logic        i_rst;       // Synchronous reset
  logic        i_large_ram; // RAM size option
  oad_instr_t  i_instr;     // Instruction presented
  logic [7:0]  i_p1_pins, i_p2_pins, i_pi_pins, i_p3_pins;
  oad_result_t o_result;    // Result bundle
  logic [7:0]  o_first_ptr, o_second_ptr, o_stack_ptr;
  logic [7:0]  o_p1_latch, o_p1_dir, o_p2_latch, o_p2_dir;
  logic [7:0]  o_p3_latch, o_p3_dir, o_pd_latch;
  int          failures;    // Mismatch count
  int          tests_run;   // Comparison count
  logic [14:0] exp_pc;      // Program counter model
  logic [7:0]  pv;          // Port output under test
  // Writable port register, read-only pin input and reserved offsets
  logic [7:0]  la [7] = '{8'hD0, 8'hD1, 8'hD4, 8'hD5, 8'hD8, 8'hD9, 8'hDC};
  logic [7:0]  pa [4] = '{8'hD2, 8'hD6, 8'hD7, 8'hDA};
  logic [7:0]  ua [6] = '{8'h80, 8'hBF, 8'hC0, 8'hCF, 8'hE0, 8'hE8};

  oad_data_map oad_data_map_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_large_ram(i_large_ram),
    .i_instr(i_instr), .i_p1_pins(i_p1_pins), .i_p2_pins(i_p2_pins),
    .i_pi_pins(i_pi_pins), .i_p3_pins(i_p3_pins), .o_result(o_result),
    .o_first_ptr(o_first_ptr), .o_second_ptr(o_second_ptr),
    .o_stack_ptr(o_stack_ptr), .o_p1_latch(o_p1_latch),
    .o_p1_dir(o_p1_dir), .o_p2_latch(o_p2_latch), .o_p2_dir(o_p2_dir),
    .o_p3_latch(o_p3_latch), .o_p3_dir(o_p3_dir), .o_pd_latch(o_pd_latch)
  );

  // ****************************************
  // Clock and watchdog
  // ****************************************
  always #5 i_clk_sys = ~i_clk_sys;

  // Tests need well under 2000 cycles; give ten times that
  initial begin
    #200000;
    failures++;
    final_report();
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare one value and log a mismatch
  task automatic chk(input string nm, input logic [14:0] s,
                     input logic [14:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] s,
                      input logic [7:0] e);
    chk(nm, {7'h00, s}, {7'h00, e});
  endtask

  // Issue one instruction, wait for its edge, check done, nop and pc
  // Extra bits xs: second pointer, decrement, bit number
  task automatic go(input oad_op_t op, input oad_mode_t md,
                    input logic [7:0] f, input logic [4:0] xs,
                    input logic signed [5:0] rel);
    oad_instr_t t;
    logic       jn;
    t = '{1'b1, op, md, xs[4], xs[3], f, xs[2:0], rel};
    jn = (op == OAD_OP_JUMP) && (rel == 6'h01);
    @(posedge i_clk_sys);
    i_instr <= t;
    @(posedge i_clk_sys);
    i_instr <= '0;
    #1;
    chk8("done", {7'h00, o_result.done}, 8'h01);
    chk8("nop", {7'h00, o_result.no_operation}, {7'h00, jn});
    if (op == OAD_OP_JUMP && !jn) begin
      exp_pc = exp_pc + {{9{rel[5]}}, rel};
    end else begin
      exp_pc = exp_pc + 15'h0001;
    end
    chk("pc", o_result.pc, exp_pc);
  endtask

  // Load the accumulator and compare it
  task automatic ld(input oad_mode_t md, input logic [7:0] f,
                    input logic [4:0] xs, input logic [7:0] e);
    go(OAD_OP_LOAD, md, f, xs, 6'h00);
    chk8("acc", o_result.acc, e);
  endtask

  task automatic st(input oad_mode_t md, input logic [7:0] f,
                    input logic [4:0] xs);
    go(OAD_OP_STORE, md, f, xs, 6'h00);
  endtask

  // Immediate load then direct store
  task automatic put(input logic [7:0] v, input logic [7:0] a);
    ld(OAD_MODE_IMMED, v, 5'h00, v);
    st(OAD_MODE_DIRECT, a, 5'h00);
  endtask

  // Arithmetic on an immediate; e is carry, half-carry, accumulator
  task automatic alu(input oad_op_t op, input logic [7:0] f,
                     input logic [9:0] e);
    go(op, OAD_MODE_IMMED, f, 5'h00, 6'h00);
    chk8("acc", o_result.acc, e[7:0]);
    chk8("flags", {6'h00, o_result.carry, o_result.half}, {6'h00, e[9:8]});
  endtask

  task automatic final_report();
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    i_large_ram = 1'b0;
    i_instr = '0;
    {i_p1_pins, i_p2_pins, i_pi_pins, i_p3_pins} = 32'hA53C960F;
    failures = 0;
    tests_run = 0;
    exp_pc = 15'h0000;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk("pc", o_result.pc, 15'h0000);
    chk8("ptrs", o_first_ptr | o_second_ptr | o_stack_ptr, 8'h00);
    // Backward jump from zero wraps the whole counter, then return
    go(OAD_OP_JUMP, OAD_MODE_IMMED, 8'h00, 5'h00, 6'h21);
    go(OAD_OP_JUMP, OAD_MODE_IMMED, 8'h00, 5'h00, 6'h1F);
    go(OAD_OP_JUMP, OAD_MODE_IMMED, 8'h00, 5'h00, 6'h01);
    // Small and large RAM edges and the unused hole above each
    put(8'h5A, 8'h2F);
    ld(OAD_MODE_DIRECT, 8'h2F, 5'h00, 8'h5A);
    put(8'h00, 8'h30);
    ld(OAD_MODE_DIRECT, 8'h30, 5'h00, 8'hFF);
    ld(OAD_MODE_DIRECT, 8'h7F, 5'h00, 8'hFF);
    i_large_ram <= 1'b1;
    put(8'hA6, 8'h6F);
    ld(OAD_MODE_DIRECT, 8'h6F, 5'h00, 8'hA6);
    put(8'h00, 8'h70);
    ld(OAD_MODE_DIRECT, 8'h70, 5'h00, 8'hFF);
    // Reserved spaces hold nothing
    foreach (ua[i]) begin
      put(8'h00, ua[i]);
      ld(OAD_MODE_DIRECT, ua[i], 5'h00, 8'hFF);
    end
    // Port latches and direction registers
    foreach (la[i]) begin
      put(8'(8'h11 * (i + 1)), la[i]);
      ld(OAD_MODE_DIRECT, la[i], 5'h00, 8'(8'h11 * (i + 1)));
      case (i)
        0: pv = o_p1_latch;
        1: pv = o_p1_dir;
        2: pv = o_p2_latch;
        3: pv = o_p2_dir;
        4: pv = o_p3_latch;
        5: pv = o_p3_dir;
        default: pv = o_pd_latch;
      endcase
      chk8("port", pv, 8'(8'h11 * (i + 1)));
    end
    // Pin inputs ignore writes
    foreach (pa[i]) begin
      put(8'h00, pa[i]);
      ld(OAD_MODE_DIRECT, pa[i], 5'h00, 8'(32'hA53C960F >> (24 - 8 * i)));
    end
    // Shift, timer and reload bytes
    for (int a = 8'hE9; a <= 8'hED; a++) begin
      put(8'(a) ^ 8'h5C, 8'(a));
      ld(OAD_MODE_DIRECT, 8'(a), 5'h00, 8'(a) ^ 8'h5C);
    end
    // Register memory and pointer registers
    put(8'h10, 8'hFE);
    chk8("first", o_first_ptr, 8'h10);
    put(8'h20, 8'hFC);
    chk8("second", o_second_ptr, 8'h20);
    put(8'h3E, 8'hFD);
    chk8("stack", o_stack_ptr, 8'h3E);
    ld(OAD_MODE_IMMED, 8'h44, 5'h00, 8'h44);
    st(OAD_MODE_REG, 8'h35, 5'h00);
    ld(OAD_MODE_DIRECT, 8'hF5, 5'h00, 8'h44);
    ld(OAD_MODE_REG, 8'h0E, 5'h00, 8'h10);
    // Bit set and clear on a RAM byte
    put(8'h00, 8'h10);
    go(OAD_OP_SBIT, OAD_MODE_DIRECT, 8'h10, 5'h07, 6'h00);
    go(OAD_OP_SBIT, OAD_MODE_DIRECT, 8'h10, 5'h00, 6'h00);
    ld(OAD_MODE_DIRECT, 8'h10, 5'h00, 8'h81);
    go(OAD_OP_RBIT, OAD_MODE_DIRECT, 8'h10, 5'h07, 6'h00);
    ld(OAD_MODE_DIRECT, 8'h10, 5'h00, 8'h01);
    // Indirect through each pointer
    put(8'h5A, 8'h20);
    put(8'h66, 8'h00);
    ld(OAD_MODE_INDIRECT, 8'h00, 5'h00, 8'h01);
    ld(OAD_MODE_INDIRECT, 8'h00, 5'h10, 8'h5A);
    ld(OAD_MODE_IMMED, 8'hC3, 5'h00, 8'hC3);
    st(OAD_MODE_INDIRECT, 8'h00, 5'h10);
    ld(OAD_MODE_DIRECT, 8'h20, 5'h00, 8'hC3);
    // Auto step with wrap at both ends
    put(8'hFF, 8'hFE);
    ld(OAD_MODE_AUTO, 8'h00, 5'h00, 8'h00);
    chk8("first", o_first_ptr, 8'h00);
    ld(OAD_MODE_AUTO, 8'h00, 5'h08, 8'h66);
    chk8("first", o_first_ptr, 8'hFF);
    ld(OAD_MODE_AUTO, 8'h00, 5'h10, 8'hC3);
    chk8("second", o_second_ptr, 8'h21);
    // Carry arithmetic
    ld(OAD_MODE_IMMED, 8'h0F, 5'h00, 8'h0F);
    alu(OAD_OP_ADC, 8'h01, 10'h110);
    ld(OAD_MODE_IMMED, 8'hFF, 5'h00, 8'hFF);
    alu(OAD_OP_ADC, 8'h01, 10'h300);
    ld(OAD_MODE_IMMED, 8'h05, 5'h00, 8'h05);
    alu(OAD_OP_SUBTRACT_WITH_CARRY_OP, 8'h03, 10'h302);
    alu(OAD_OP_SUBTRACT_WITH_CARRY_OP, 8'h03, 10'h0FF);
    // Equality test: match runs on, mismatch skips the next one
    go(OAD_OP_EQ, OAD_MODE_IMMED, 8'hFF, 5'h00, 6'h00);
    chk8("skip", {7'h00, o_result.skip}, 8'h00);
    go(OAD_OP_EQ, OAD_MODE_DIRECT, 8'h10, 5'h00, 6'h00);
    chk8("skip", {7'h00, o_result.skip}, 8'h01);
    ld(OAD_MODE_IMMED, 8'h55, 5'h00, 8'hFF);
    chk8("skip", {7'h00, o_result.skip}, 8'h00);
    final_report();
  end

endmodule
